// ### rtl/uart_irq_line_format.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module uart_irq_line_format
    import uart_irq_fmt_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire irq_cause_t cause_in,
    input wire logic fifo_enable_in,
    input wire logic [7:0] enhanced_feature_reg_in,
    input wire logic tx_serial_in,
    output logic tx_line_out,
    output line_fmt_t line_fmt_out,
    output logic irq_out
);

    logic [1:0] rst_sync_ff;
    logic rst_n;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    function automatic logic [5:0] code_of(input cause_t c);
        case (c)
            CAUSE_LINE_ERR: code_of = CODE_LINE_ERR;
            CAUSE_RX_DATA: code_of = CODE_RX_DATA;
            CAUSE_RX_TIMEOUT: code_of = CODE_RX_TIMEOUT;
            CAUSE_TX_EMPTY: code_of = CODE_TX_EMPTY;
            CAUSE_MODEM: code_of = CODE_MODEM;
            CAUSE_XOFF: code_of = CODE_XOFF;
            CAUSE_FLOW: code_of = CODE_FLOW;
            default: code_of = CODE_NONE;
        endcase
    endfunction

    // Level of each cause as it stands now, indexed by cause_t.
    logic [7:0] cause_level;
    logic enh_enable;
    logic xoff_hold_ff;
    logic nxt_xoff_hold;

    assign enh_enable = enhanced_feature_reg_in[EFR_ENH_BIT];

    // A fresh Xoff wins over an Xon in the same cycle, so none is lost.
    assign nxt_xoff_hold = (cause_in.xoff_detect && enh_enable) ? 1'b1 :
                           cause_in.xon_detect ? 1'b0 :
                           (xoff_hold_ff && enh_enable);

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            xoff_hold_ff <= 1'b0;
        end else begin
            xoff_hold_ff <= nxt_xoff_hold;
        end
    end

    assign cause_level[CAUSE_NONE] = 1'b0;
    assign cause_level[CAUSE_LINE_ERR] = cause_in.line_error;
    assign cause_level[CAUSE_RX_DATA] = cause_in.rx_data_ready;
    assign cause_level[CAUSE_RX_TIMEOUT] = cause_in.rx_timeout;
    assign cause_level[CAUSE_TX_EMPTY] = cause_in.tx_holding_empty;
    assign cause_level[CAUSE_MODEM] = cause_in.modem_change;
    assign cause_level[CAUSE_XOFF] = enh_enable &&
        (xoff_hold_ff || cause_in.special_char);
    assign cause_level[CAUSE_FLOW] = enh_enable &&
        cause_in.flow_change;

    // Fixed priority; time-out outranks plain data ready at level 2.
    cause_t winner;
    assign winner = cause_level[CAUSE_LINE_ERR] ? CAUSE_LINE_ERR :
        cause_level[CAUSE_RX_TIMEOUT] ? CAUSE_RX_TIMEOUT :
        cause_level[CAUSE_RX_DATA] ? CAUSE_RX_DATA :
        cause_level[CAUSE_TX_EMPTY] ? CAUSE_TX_EMPTY :
        cause_level[CAUSE_MODEM] ? CAUSE_MODEM :
        cause_level[CAUSE_XOFF] ? CAUSE_XOFF :
        cause_level[CAUSE_FLOW] ? CAUSE_FLOW : CAUSE_NONE;

    // The presented cause is frozen until its own condition has cleared,
    // so a higher cause arriving later cannot pull the code away from
    // software in the middle of its service routine.
    cause_t shown_ff;
    cause_t nxt_shown;
    logic shown_serviced;
    assign shown_serviced = !cause_level[shown_ff];
    assign nxt_shown = shown_serviced ? winner : shown_ff;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            shown_ff <= CAUSE_NONE;
        end else begin
            shown_ff <= nxt_shown;
        end
    end

    logic [7:0] int_source_value;
    assign int_source_value = {{2{fifo_enable_in}},
                               code_of(shown_ff)};

    // Line format register and its decoded view.
    logic [7:0] line_format_reg_ff;
    logic [7:0] nxt_line_format;
    line_fmt_t fmt_dec;
    logic [2:0] par_sel;
    logic [1:0] wlen_sel;

    assign par_sel = line_format_reg_ff[LF_PARITY_LSB +: 3];
    assign wlen_sel = line_format_reg_ff[LF_WLEN_LSB +: 2];
    assign fmt_dec.divisor_access =
        line_format_reg_ff[LF_DIV_ACCESS_BIT];
    assign fmt_dec.send_break = line_format_reg_ff[LF_BREAK_BIT];
    assign fmt_dec.parity = !par_sel[0] ? PAR_NONE :
        (par_sel == 3'b001) ? PAR_ODD :
        (par_sel == 3'b011) ? PAR_EVEN :
        (par_sel == 3'b101) ? PAR_FORCE1 : PAR_FORCE0;
    assign fmt_dec.stop_half_bits = !line_format_reg_ff[LF_STOP_BIT] ?
        STOP_HALF_ONE :
        (wlen_sel == 2'b00) ? STOP_HALF_ONE_HALF : STOP_HALF_TWO;
    assign fmt_dec.word_bits = 4'h5 + {2'b00, wlen_sel};

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            line_fmt_out <= '0;
            tx_line_out <= 1'b1;
        end else begin
            line_fmt_out <= fmt_dec;
            tx_line_out <= tx_serial_in &&
                !line_format_reg_ff[LF_BREAK_BIT];
        end
    end

    // Event capture: each cause sets its sticky bit on a rising level.
    logic [7:0] cause_prev_ff;
    logic [7:0] cause_rise;
    logic [7:0] evt_status_ff;
    logic [7:0] nxt_evt_status;
    logic [7:0] evt_mask_ff;
    logic [7:0] nxt_evt_mask;
    logic status_read_clear;

    assign cause_rise = cause_level & ~cause_prev_ff;
    // A rise in the clearing cycle survives the clear.
    assign nxt_evt_status = (status_read_clear ? 8'h00 : evt_status_ff) |
                            cause_rise;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cause_prev_ff <= 8'h00;
            evt_status_ff <= 8'h00;
            irq_out <= 1'b0;
        end else begin
            cause_prev_ff <= cause_level;
            evt_status_ff <= nxt_evt_status;
            irq_out <= |(nxt_evt_status & evt_mask_ff);
        end
    end

    // AXI4-Lite write path: address and data may arrive in either order.
    logic aw_held_ff;
    logic w_held_ff;
    logic [AXI_ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_hit_fmt;
    logic wr_hit_mask;
    logic wr_hit_ro;
    logic [1:0] wr_resp;

    assign s_axi_awready_out = !aw_held_ff && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held_ff && !s_axi_bvalid_out;
    assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
    assign w_take = s_axi_wvalid_in && s_axi_wready_out;
    assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid_out;
    assign wr_hit_fmt = aw_addr_ff == ADDR_LINE_FORMAT;
    assign wr_hit_mask = aw_addr_ff == ADDR_EVT_MASK;
    // Writes to the read-only registers are answered but dropped.
    assign wr_hit_ro = (aw_addr_ff == ADDR_INT_SOURCE) ||
                       (aw_addr_ff == ADDR_EVT_STATUS);
    assign wr_resp = (wr_hit_fmt || wr_hit_mask || wr_hit_ro) ?
                     RESP_OKAY : RESP_SLVERR;
    assign nxt_line_format = (wr_fire && wr_hit_fmt && w_strb_ff[0]) ?
                             w_data_ff[7:0] : line_format_reg_ff;
    assign nxt_evt_mask = (wr_fire && wr_hit_mask && w_strb_ff[0]) ?
                          w_data_ff[7:0] : evt_mask_ff;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_in;
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (w_take) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_in;
                w_strb_ff <= s_axi_wstrb_in;
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            line_format_reg_ff <= LINE_FORMAT_RESET;
            evt_mask_ff <= EVT_MASK_RESET;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end else begin
            line_format_reg_ff <= nxt_line_format;
            evt_mask_ff <= nxt_evt_mask;
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_resp;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path: one cycle from address to data.
    logic rd_take;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic rd_hit;

    assign s_axi_arready_out = !s_axi_rvalid_out;
    assign rd_take = s_axi_arvalid_in && s_axi_arready_out;
    // Reading the source register touches nothing else.
    assign rd_data =
        (s_axi_araddr_in == ADDR_INT_SOURCE) ?
            {24'h00_0000, int_source_value} :
        (s_axi_araddr_in == ADDR_LINE_FORMAT) ?
            {24'h00_0000, line_format_reg_ff} :
        (s_axi_araddr_in == ADDR_EVT_STATUS) ?
            {24'h00_0000, evt_status_ff} :
        (s_axi_araddr_in == ADDR_EVT_MASK) ?
            {24'h00_0000, evt_mask_ff} : 32'h0000_0000;
    assign rd_hit = (s_axi_araddr_in == ADDR_INT_SOURCE) ||
                    (s_axi_araddr_in == ADDR_LINE_FORMAT) ||
                    (s_axi_araddr_in == ADDR_EVT_STATUS) ||
                    (s_axi_araddr_in == ADDR_EVT_MASK);
    assign rd_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    assign status_read_clear = rd_take &&
                               (s_axi_araddr_in == ADDR_EVT_STATUS);

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_data;
                s_axi_rresp_out <= rd_resp;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### rtl/uart_irq_fmt_pkg.sv
`default_nettype none
package uart_irq_fmt_pkg;
    localparam int AXI_ADDR_W = 4;
    localparam logic [3:0] ADDR_INT_SOURCE = 4'h0;
    localparam logic [3:0] ADDR_LINE_FORMAT = 4'h4;
    localparam logic [3:0] ADDR_EVT_STATUS = 4'h8;
    localparam logic [3:0] ADDR_EVT_MASK = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [7:0] LINE_FORMAT_RESET = 8'h00;
    localparam logic [7:0] EVT_MASK_RESET = 8'h00;
    localparam int LF_DIV_ACCESS_BIT = 7;
    localparam int LF_BREAK_BIT = 6;
    localparam int LF_PARITY_LSB = 3;
    localparam int LF_STOP_BIT = 2;
    localparam int LF_WLEN_LSB = 0;
    localparam int SRC_FIFO_LSB = 6;
    localparam int EFR_ENH_BIT = 4;

    localparam logic [5:0] CODE_LINE_ERR = 6'h06;
    localparam logic [5:0] CODE_RX_DATA = 6'h04;
    localparam logic [5:0] CODE_RX_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_TX_EMPTY = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_XOFF = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;

    // Stop length in half bit times.
    localparam logic [2:0] STOP_HALF_ONE = 3'h2;
    localparam logic [2:0] STOP_HALF_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_HALF_TWO = 3'h4;

    typedef enum logic [2:0] {
        PAR_NONE = 3'b000,
        PAR_ODD = 3'b001,
        PAR_EVEN = 3'b010,
        PAR_FORCE1 = 3'b011,
        PAR_FORCE0 = 3'b100
    } parity_mode_t;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_LINE_ERR = 3'b001,
        CAUSE_RX_DATA = 3'b010,
        CAUSE_RX_TIMEOUT = 3'b011,
        CAUSE_TX_EMPTY = 3'b100,
        CAUSE_MODEM = 3'b101,
        CAUSE_XOFF = 3'b110,
        CAUSE_FLOW = 3'b111
    } cause_t;

    typedef struct packed {
        logic line_error;
        logic rx_data_ready;
        logic rx_timeout;
        logic tx_holding_empty;
        logic modem_change;
        logic xoff_detect;
        logic xon_detect;
        logic special_char;
        logic flow_change;
    } irq_cause_t;

    typedef struct packed {
        logic divisor_access;
        logic send_break;
        parity_mode_t parity;
        logic [2:0] stop_half_bits;
        logic [3:0] word_bits;
    } line_fmt_t;
endpackage
`default_nettype wire

// ### sim/line_listener.sv
`default_nettype none
module line_listener (
    input wire logic clk_in,
    input wire logic line_in,
    output int low_run_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A receiver sees a break as a long run of low bit times.
    always @(posedge clk_in) begin
        low_run_out <= line_in ? 0 : low_run_out + 1;
    end
endmodule
`default_nettype wire

// ### sim/uart_irq_fmt_checker.sv
`default_nettype none
module uart_irq_fmt_checker
    import uart_irq_fmt_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire irq_cause_t cause_in,
    input wire logic fifo_enable_in,
    input wire logic [7:0] enhanced_feature_reg_in,
    input wire logic tx_serial_in,
    input wire logic tx_line_out,
    input wire line_fmt_t line_fmt_out
);
    logic [2:0] up_ff;
    logic [9:0] h1_ff;
    logic [9:0] h2_ff;
    wire logic [9:0] now_w = {enhanced_feature_reg_in[4], cause_in};
    wire logic live = up_ff == 3'h7;
    wire logic src_rd = s_axi_arvalid_in && s_axi_arready_out
        && s_axi_araddr_in == ADDR_INT_SOURCE;
    // Levels unchanged for two edges, so the presented cause has settled.
    wire logic steady = now_w == h1_ff && h1_ff == h2_ff && !now_w[9]
        && cause_in[3:0] == 4'h0 && $countones(cause_in[8:4]) < 2;
    wire logic [5:0] exp_code = cause_in.line_error ? CODE_LINE_ERR
        : cause_in.rx_timeout ? CODE_RX_TIMEOUT
        : cause_in.rx_data_ready ? CODE_RX_DATA
        : cause_in.tx_holding_empty ? CODE_TX_EMPTY
        : cause_in.modem_change ? CODE_MODEM : CODE_NONE;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_ff <= 3'h0;
            h1_ff <= 10'h000;
            h2_ff <= 10'h000;
        end else begin
            up_ff <= live ? up_ff : up_ff + 3'h1;
            h1_ff <= now_w;
            h2_ff <= h1_ff;
        end
    end
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in || !live);
    a_break_low: assert property (
        tx_line_out == ($past(tx_serial_in) && !line_fmt_out.send_break))
        else $error("break output mismatch");
    a_stop_len: assert property (
        line_fmt_out.stop_half_bits == STOP_HALF_ONE
        || line_fmt_out.stop_half_bits == (line_fmt_out.word_bits == 4'h5
        ? STOP_HALF_ONE_HALF : STOP_HALF_TWO))
        else $error("stop length mismatch");
    a_word_len: assert property (
        line_fmt_out.word_bits inside {[4'h5:4'h8]})
        else $error("word length out of range");
    a_fifo_bits: assert property (
        src_rd |=> s_axi_rdata_out[7:6] == {2{$past(fifo_enable_in)}})
        else $error("fifo bits mismatch");
    a_src_code: assert property (
        src_rd && steady |=> s_axi_rdata_out[5:0] == $past(exp_code))
        else $error("source code mismatch");
    a_pend_flag: assert property (
        src_rd && |cause_in[8:4] && |h1_ff[8:4] |=> !s_axi_rdata_out[0])
        else $error("pending flag mismatch");
    a_read_answer: assert property (
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
        |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    a_high_zero: assert property (
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule
bind uart_irq_line_format uart_irq_fmt_checker uart_irq_fmt_checker_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .cause_in(cause_in),
    .fifo_enable_in(fifo_enable_in),
    .enhanced_feature_reg_in(enhanced_feature_reg_in),
    .tx_serial_in(tx_serial_in), .tx_line_out(tx_line_out),
    .line_fmt_out(line_fmt_out));
`default_nettype wire

// ### sim/uart_irq_priority_and_line_format_tb.sv
`default_nettype none
module uart_irq_priority_and_line_format_tb import uart_irq_fmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
    logic clk, rstn, awv, wv, bready, arv, rready, fifo_en, txs, irq, txl;
    logic awready, wready, bvalid, arready, rvalid;
    logic late_b;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [2:0] sh;
    logic [7:0] enh, v;
    irq_cause_t cause;
    line_fmt_t lf;
    int miscompares, checks_done, low_run;
    logic [2:0] pc [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    parity_mode_t pm [5] = '{PAR_NONE, PAR_ODD, PAR_EVEN, PAR_FORCE1,
        PAR_FORCE0};
    int di [4] = '{8, 6, 7, 4};
    logic [7:0] dc [4] = '{8'hCC, 8'hC4, 8'hC0, 8'hC1};
    uart_irq_line_format uart_irq_line_format_i (
        .sys_clk_in(clk), .resetn_in(rstn), .s_axi_awaddr_in(awa),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .cause_in(cause), .fifo_enable_in(fifo_en),
        .enhanced_feature_reg_in(enh), .tx_serial_in(txs),
        .tx_line_out(txl), .line_fmt_out(lf), .irq_out(irq));
    line_listener line_listener_i (.clk_in(clk), .line_in(txl),
        .low_run_out(low_run));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Ready is sampled at the falling edge, where it already shows the
    // value that the next rising edge will see.
    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        logic at;
        logic wt;
        logic bt;
        logic bw;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, dat};
        awv <= 1'b1;
        wv <= 1'b1;
        // A late bready makes the slave hold its response for a while.
        bready <= !late_b;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            at = awv && awready;
            wt = wv && wready;
            bt = bvalid && bready;
            bw = bvalid && !bready;
            r = bresp;
            @(posedge clk);
            if (at) awv <= 1'b0;
            if (wt) wv <= 1'b0;
            if (bw) bready <= 1'b1;
            if (bt) begin
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
    endtask
    task automatic rd(input logic [3:0] a);
        logic at;
        logic rt;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            at = arv && arready;
            rt = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (at) arv <= 1'b0;
            if (rt) begin
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rd(a);
        `CHK(d, {24'h0, e})
    endtask
    task automatic pulse(input int b);
        cause[b] <= 1'b1;
        @(posedge clk);
        cause[b] <= 1'b0;
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        {awv, wv, bready, arv, rready, fifo_en, rstn, late_b} = '0;
        {awa, ara, wd, enh, cause} = '0;
        txs = 1'b1;
        cyc(8);
        rstn <= 1'b1;
        cyc(4);
        rchk(ADDR_INT_SOURCE, 8'h01);
        rchk(ADDR_LINE_FORMAT, 8'h00);
        rchk(ADDR_EVT_MASK, 8'h00);
        for (int wl = 0; wl < 4; wl++) begin
            for (int s = 0; s < 2; s++) begin
                for (int k = 0; k < 5; k++) begin
                    v = {2'b00, pc[k], s[0], wl[1:0]};
                    sh = s == 0 ? STOP_HALF_ONE
                        : wl == 0 ? STOP_HALF_ONE_HALF : STOP_HALF_TWO;
                    wr(ADDR_LINE_FORMAT, v);
                    @(negedge clk);
                    `CHK(lf.word_bits, 4'(wl + 5))
                    `CHK(lf.stop_half_bits, sh)
                    `CHK(lf.parity, pm[k])
                    rchk(ADDR_LINE_FORMAT, v);
                end
            end
        end
        wr(ADDR_LINE_FORMAT, 8'hC3);
        cyc(20);
        `CHK(lf.divisor_access, 1'b1)
        `CHK(low_run > 15, 1'b1)
        late_b = 1'b1;
        wr(ADDR_INT_SOURCE, 8'hFF);
        late_b = 1'b0;
        `CHK(r, RESP_OKAY)
        rchk(ADDR_INT_SOURCE, 8'h01);
        rchk(ADDR_LINE_FORMAT, 8'hC3);
        wr(ADDR_LINE_FORMAT, 8'h03);
        txs <= 1'b0;
        cyc(2);
        `CHK(txl, 1'b0)
        txs <= 1'b1;
        cyc(2);
        `CHK(txl, 1'b1)
        rd(4'h2);
        `CHK(r, RESP_SLVERR)
        cause.tx_holding_empty <= 1'b1;
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h02);
        cause.line_error <= 1'b1;
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h02);
        {cause.rx_data_ready, cause.rx_timeout, cause.modem_change} <= 3'h7;
        cause.tx_holding_empty <= 1'b0;
        fifo_en <= 1'b1;
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'hC6);
        for (int i = 0; i < 4; i++) begin
            cause[di[i]] <= 1'b0;
            cyc(3);
            rchk(ADDR_INT_SOURCE, dc[i]);
        end
        fifo_en <= 1'b0;
        pulse(3);
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h01);
        enh <= 8'h10;
        cyc(1);
        pulse(3);
        cyc(10);
        rchk(ADDR_INT_SOURCE, 8'h10);
        pulse(2);
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h01);
        cause.flow_change <= 1'b1;
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h20);
        cause.flow_change <= 1'b0;
        cause.special_char <= 1'b1;
        cyc(3);
        rchk(ADDR_INT_SOURCE, 8'h10);
        cause.special_char <= 1'b0;
        enh <= 8'h00;
        cyc(3);
        rd(ADDR_EVT_STATUS);
        cause.tx_holding_empty <= 1'b1;
        cyc(3);
        `CHK(irq, 1'b0)
        wr(ADDR_EVT_MASK, 8'h04);
        rchk(ADDR_EVT_MASK, 8'h04);
        `CHK(irq, 1'b0)
        cause.rx_data_ready <= 1'b1;
        cyc(3);
        `CHK(irq, 1'b1)
        rchk(ADDR_EVT_STATUS, 8'h14);
        cyc(2);
        `CHK(irq, 1'b0)
        rchk(ADDR_EVT_STATUS, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
